// *** hw/plg_pkg.sv ***
package plg_pkg;

	// Register indexes; the byte address is four times the index.
	localparam logic [9:0] IDX_CABLE_DIAG    = 10'h18A;
	localparam logic [9:0] IDX_SIGNAL_QUAL   = 10'h218;
	localparam logic [9:0] IDX_IO_PIN        = 10'h302;
	localparam logic [9:0] IDX_PIN0          = 10'h303;
	localparam logic [9:0] IDX_PIN1          = 10'h304;
	localparam logic [9:0] IDX_PIN2          = 10'h305;
	localparam logic [9:0] IDX_EVENT_STATUS  = 10'h310;
	localparam logic [9:0] IDX_EVENT_MASK    = 10'h311;

	// Field positions.
	localparam int IO_IMPEDANCE_LSB  = 14;
	localparam int IO_SPARE13_BIT    = 13;
	localparam int IO_SPARE12_LSB    = 9;
	localparam int IO_RMII_BIT       = 8;
	localparam int IO_SPARE7_BIT     = 7;
	localparam int IO_CLKOUT_OFF_BIT = 6;
	localparam int PIN_FUNC_LSB      = 0;
	localparam int PIN_CLK_LSB       = 3;
	localparam int DIAG_POLARITY_BIT = 11;
	localparam int DIAG_CROSS_BIT    = 5;

	// Reset values.
	localparam logic [1:0] IMPEDANCE_RESET   = 2'h0;
	localparam logic [3:0] SPARE12_RESET     = 4'h0;
	localparam logic       SPARE_BIT_RESET   = 1'b0;
	localparam logic       CLKOUT_OFF_RESET  = 1'b0;
	localparam logic [2:0] PIN_CLK_RESET     = 3'h1;
	localparam logic [2:0] PIN_FUNC_RESET    = 3'h0;
	localparam logic [2:0] PIN1_ENH_RESET    = 3'h6;
	localparam logic [15:0] QUAL_RESET       = 16'h0000;

	// Pin function codes.
	localparam logic [2:0] FUNC_STATUS = 3'h0;
	localparam logic [2:0] FUNC_CLOCK  = 3'h1;
	localparam logic [2:0] FUNC_WAKE   = 3'h2;
	localparam logic [2:0] FUNC_3      = 3'h3;
	localparam logic [2:0] FUNC_IRQ    = 3'h4;
	localparam logic [2:0] FUNC_5      = 3'h5;
	localparam logic [2:0] FUNC_6      = 3'h6;
	localparam logic [2:0] FUNC_HIGH   = 3'h7;

	// Internal clock choices.
	localparam logic [2:0] CLK_PLL       = 3'h5;
	localparam logic [2:0] CLK_RECOVERED = 3'h6;

	// Event bits of the status and mask registers.
	localparam int EVENT_W       = 3;
	localparam int EV_CROSS      = 0;
	localparam int EV_DIAG_DONE  = 1;
	localparam int EV_RMII_HW    = 2;

	// Signals that may be routed onto a status pin.
	typedef struct packed {
		logic wake_on_lan;
		logic interrupt_req;
		logic collision;
		logic transmit_error;
		logic pll_clock;
		logic recovered_clock;
		logic ref_clock_25m;
	} plg_sources_type;

	// One cable diagnosis result.
	typedef struct packed {
		logic valid;
		logic peak_polarity;
		logic cross_short;
	} plg_diag_type;

endpackage

// *** hw/plg_pin_drive.sv ***
`timescale 1ns/10ps
`default_nettype none
module plg_pin_drive import plg_pkg::*; #(
	parameter int PIN = 0
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic [2:0]      func_i,
	input  wire logic [2:0]      clk_choice_i,
	input  wire logic            status_ind_i,
	input  wire logic            force_ref_i,
	input  wire plg_sources_type src_i,
	output logic                 pin_o
);

	// Picks one internal clock, or low for a reserved choice.
	function automatic logic pick_clock(input logic [2:0] sel, input plg_sources_type s);
		case (sel)
			CLK_PLL:       return s.pll_clock;
			CLK_RECOVERED: return s.recovered_clock;
			default:       return 1'b0;
		endcase
	endfunction

	logic next_pin; // Value the pin takes at the next edge.

	// Decodes the function code for this pin position.
	always_comb begin
		case (func_i)
			FUNC_STATUS: next_pin = status_ind_i;
			FUNC_CLOCK:  next_pin = (PIN != 2) ? pick_clock(clk_choice_i, src_i) : 1'b0;
			FUNC_WAKE:   next_pin = src_i.wake_on_lan;
			FUNC_3:      next_pin = (PIN == 2) ? src_i.collision : 1'b0;
			FUNC_IRQ:    next_pin = src_i.interrupt_req;
			FUNC_5:      next_pin = (PIN == 1) ? src_i.transmit_error : (PIN == 2) ? src_i.collision : 1'b0;
			FUNC_6:      next_pin = (PIN == 1) ? src_i.ref_clock_25m : (PIN == 2) ? src_i.collision : 1'b0;
			FUNC_HIGH:   next_pin = (PIN != 1);
			default:     next_pin = 1'b0;
		endcase
		if (force_ref_i) begin
			next_pin = src_i.ref_clock_25m;
		end
	end

	// Registers the pin so the output comes straight from a flop.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_o <= 1'b0;
		end else begin
			pin_o <= next_pin;
		end
	end

endmodule // plg_pin_drive
`default_nettype wire

// *** hw/plg_event_flags.sv ***
`timescale 1ns/10ps
`default_nettype none
module plg_event_flags import plg_pkg::*; (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic [EVENT_W-1:0] event_i,
	input  wire logic               read_clear_i,
	input  wire logic               mask_we_i,
	input  wire logic [EVENT_W-1:0] mask_data_i,
	output logic [EVENT_W-1:0]      status_o,
	output logic [EVENT_W-1:0]      mask_o,
	output logic                    irq_o
);

	// Sticky flags; an event in the clearing cycle is kept.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_o <= '0;
		end else if (read_clear_i) begin
			status_o <= event_i;
		end else begin
			status_o <= status_o | event_i;
		end
	end

	// Mask register, one enable per flag.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mask_o <= '0;
		end else if (mask_we_i) begin
			mask_o <= mask_data_i;
		end
	end

	// Level interrupt, high while an enabled flag is set.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_o & mask_o);
		end
	end

endmodule // plg_event_flags
`default_nettype wire

// *** hw/plg_pin_config.sv ***
`timescale 1ns/10ps
`default_nettype none
module plg_pin_config import plg_pkg::*; (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// Avalon-MM slave, byte addressed, 32-bit data.
	input  wire logic [11:0]     avs_address,
	input  wire logic            avs_read,
	input  wire logic            avs_write,
	input  wire logic [31:0]     avs_writedata,
	input  wire logic [3:0]      avs_byteenable,
	output logic [31:0]          avs_readdata,
	output logic                 avs_waitrequest,
	// Straps and mode.
	input  wire logic            enhanced_mode_i,
	input  wire logic            rmii_meaning_strap_i,
	input  wire logic            rmii_mode_i,
	// Hardware update of the receive pin meaning.
	input  wire logic            rmii_meaning_hw_we_i,
	input  wire logic            rmii_meaning_hw_i,
	// Receive status sources for the RMII pin.
	input  wire logic            carrier_sense_dv_i,
	input  wire logic            receive_valid_i,
	// Pin sources.
	input  wire logic [2:0]      status_ind_i,
	input  wire plg_sources_type src_i,
	// Cable diagnosis and signal quality results.
	input  wire plg_diag_type    diag_i,
	input  wire logic            signal_quality_we_i,
	input  wire logic [15:0]     signal_quality_i,
	// Pins and controls.
	output logic                 status_pin0_o,
	output logic                 status_pin1_o,
	output logic                 status_pin2_o,
	output logic                 rmii_receive_pin_o,
	output logic [1:0]           mac_termination_o,
	output logic                 irq_o
);

	// True when a byte address selects the given register index.
	function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
		return addr[11:2] == idx;
	endfunction

	// Merges the low two write lanes into a 16-bit register image.
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wd[7:0];
		end
		if (be[1]) begin
			res[15:8] = wd[15:8];
		end
		return res;
	endfunction

	// Bus handshake state.
	logic        accept;        // Request taken at this edge.
	logic        wr_accept;     // Write taken at this edge.
	logic        rd_load;       // Read data loaded at this edge.
	logic [15:0] next_rdata;    // Read mux result.
	logic [15:0] wr_io;         // Merged image for the I/O register.
	logic [15:0] wr_pin1;       // Merged image for pin 1.
	logic [15:0] wr_pin2;       // Merged image for pin 2.
	logic [15:0] wr_pin0;       // Merged image for pin 0.
	logic [15:0] wr_mask;       // Merged image for the mask.

	// Strap load tracking.
	logic        strap_loaded;  // Set once straps have been sampled.

	// I/O configuration fields.
	logic [1:0]  impedance;     // Termination strength.
	logic        spare13;       // Reserved, holds writes.
	logic [3:0]  spare12;       // Reserved, holds writes.
	logic        rmii_receive_pin_meaning; // 0 carrier-sense/valid, 1 receive valid.
	logic        spare7;        // Reserved, holds writes.
	logic        ref_clock_out_disable;    // 1 gives the shared pin to pin 1.

	// Status pin configuration fields.
	logic [2:0]  pin0_function_choice; // Read-only function code.
	logic [2:0]  pin0_clock_choice;    // Internal clock for pin 0.
	logic [2:0]  pin1_function_choice; // Writable function code.
	logic [2:0]  pin1_clock_choice;    // Internal clock for pin 1.
	logic [2:0]  pin2_function_choice; // Writable function code.
	logic [2:0]  pin2_spare;           // Reserved, holds writes.

	// Results.
	logic        peak_polarity;        // First peak polarity.
	logic        cross_short;          // Short between the pair wires.
	logic [15:0] signal_quality_error; // Mean square error.

	// Events.
	logic [EVENT_W-1:0] events;        // One-cycle event pulses.
	logic [EVENT_W-1:0] ev_status;     // Sticky flags.
	logic [EVENT_W-1:0] ev_mask;       // Flag enables.
	logic               ev_read_clear; // Status read data loaded.
	logic               force_ref;     // Shared pin carries the clock.

	// A request is taken at the edge where waitrequest is already low.
	assign accept    = (avs_read | avs_write) & ~avs_waitrequest;
	assign wr_accept = avs_write & ~avs_waitrequest;
	assign rd_load   = avs_read & avs_waitrequest;

	// Write images, byte lanes applied to the current contents.
	assign wr_io   = merge({impedance, spare13, spare12, rmii_receive_pin_meaning,
		spare7, ref_clock_out_disable, 6'h00}, avs_writedata, avs_byteenable);
	assign wr_pin0 = merge({10'h000, pin0_clock_choice, pin0_function_choice},
		avs_writedata, avs_byteenable);
	assign wr_pin1 = merge({10'h000, pin1_clock_choice, pin1_function_choice},
		avs_writedata, avs_byteenable);
	assign wr_pin2 = merge({10'h000, pin2_spare, pin2_function_choice},
		avs_writedata, avs_byteenable);
	assign wr_mask = merge({13'h0000, ev_mask}, avs_writedata, avs_byteenable);

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		next_rdata = 16'h0000;
		if (hit(avs_address, IDX_CABLE_DIAG)) begin
			next_rdata[DIAG_POLARITY_BIT] = peak_polarity;
			next_rdata[DIAG_CROSS_BIT]    = cross_short;
		end else if (hit(avs_address, IDX_SIGNAL_QUAL)) begin
			next_rdata = signal_quality_error;
		end else if (hit(avs_address, IDX_IO_PIN)) begin
			next_rdata = {impedance, spare13, spare12, rmii_receive_pin_meaning,
				spare7, ref_clock_out_disable, 6'h00};
		end else if (hit(avs_address, IDX_PIN0)) begin
			next_rdata = {10'h000, pin0_clock_choice, pin0_function_choice};
		end else if (hit(avs_address, IDX_PIN1)) begin
			next_rdata = {10'h000, pin1_clock_choice, pin1_function_choice};
		end else if (hit(avs_address, IDX_PIN2)) begin
			next_rdata = {10'h000, pin2_spare, pin2_function_choice};
		end else if (hit(avs_address, IDX_EVENT_STATUS)) begin
			next_rdata = {13'h0000, ev_status};
		end else if (hit(avs_address, IDX_EVENT_MASK)) begin
			next_rdata = {13'h0000, ev_mask};
		end
	end

	// Waitrequest drops one cycle after a request appears and rises again
	// at the accepting edge, so every access takes two cycles.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_waitrequest <= 1'b1;
		end else if (accept) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read | avs_write) begin
			avs_waitrequest <= 1'b0;
		end
	end

	// Read data is captured while waitrequest is high and then stands.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			avs_readdata <= 32'h00000000;
		end else if (rd_load) begin
			avs_readdata <= {16'h0000, next_rdata};
		end
	end

	// Straps are sampled at the first edge after reset release.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			strap_loaded <= 1'b0;
		end else begin
			strap_loaded <= 1'b1;
		end
	end

	// Termination strength, the clock output disable and the reserved writable bits.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			impedance             <= IMPEDANCE_RESET;
			spare13               <= SPARE_BIT_RESET;
			spare12               <= SPARE12_RESET;
			spare7                <= SPARE_BIT_RESET;
			ref_clock_out_disable <= CLKOUT_OFF_RESET;
		end else if (wr_accept && hit(avs_address, IDX_IO_PIN)) begin
			impedance             <= wr_io[IO_IMPEDANCE_LSB +: 2];
			spare13               <= wr_io[IO_SPARE13_BIT];
			spare12               <= wr_io[IO_SPARE12_LSB +: 4];
			spare7                <= wr_io[IO_SPARE7_BIT];
			ref_clock_out_disable <= wr_io[IO_CLKOUT_OFF_BIT];
		end
	end

	// Receive pin meaning: strap default, then hardware or software.
	// A hardware update wins over a software write in the same cycle.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rmii_receive_pin_meaning <= 1'b0;
		end else if (!strap_loaded) begin
			rmii_receive_pin_meaning <= rmii_meaning_strap_i;
		end else if (rmii_meaning_hw_we_i) begin
			rmii_receive_pin_meaning <= rmii_meaning_hw_i;
		end else if (wr_accept && hit(avs_address, IDX_IO_PIN)) begin
			rmii_receive_pin_meaning <= wr_io[IO_RMII_BIT];
		end
	end

	// Pin 0: only the clock choice is writable, the code stays fixed.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin0_clock_choice    <= PIN_CLK_RESET;
			pin0_function_choice <= PIN_FUNC_RESET;
		end else if (wr_accept && hit(avs_address, IDX_PIN0)) begin
			pin0_clock_choice    <= wr_pin0[PIN_CLK_LSB +: 3];
			pin0_function_choice <= pin0_function_choice;
		end
	end

	// Pin 1: the function default depends on the pin mode strap.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin1_clock_choice    <= PIN_CLK_RESET;
			pin1_function_choice <= PIN_FUNC_RESET;
		end else if (!strap_loaded) begin
			pin1_function_choice <= enhanced_mode_i ? PIN1_ENH_RESET : PIN_FUNC_RESET;
		end else if (wr_accept && hit(avs_address, IDX_PIN1)) begin
			pin1_clock_choice    <= wr_pin1[PIN_CLK_LSB +: 3];
			pin1_function_choice <= wr_pin1[PIN_FUNC_LSB +: 3];
		end
	end

	// Pin 2: function code and a reserved field that holds writes.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin2_spare           <= PIN_CLK_RESET;
			pin2_function_choice <= PIN_FUNC_RESET;
		end else if (wr_accept && hit(avs_address, IDX_PIN2)) begin
			pin2_spare           <= wr_pin2[PIN_CLK_LSB +: 3];
			pin2_function_choice <= wr_pin2[PIN_FUNC_LSB +: 3];
		end
	end

	// Diagnosis results are captured when a result is delivered.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			peak_polarity <= 1'b0;
			cross_short   <= 1'b0;
		end else if (diag_i.valid) begin
			peak_polarity <= diag_i.peak_polarity;
			cross_short   <= diag_i.cross_short;
		end
	end

	// Mean square error follows each new measurement.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			signal_quality_error <= QUAL_RESET;
		end else if (signal_quality_we_i) begin
			signal_quality_error <= signal_quality_i;
		end
	end

	// Event sources for the interrupt flags.
	always_comb begin
		events               = '0;
		events[EV_CROSS]     = diag_i.valid & diag_i.cross_short;
		events[EV_DIAG_DONE] = diag_i.valid;
		events[EV_RMII_HW]   = rmii_meaning_hw_we_i;
	end

	// Reading the status register clears the flags it returned. The clear falls on the edge
	// that loads the read data, so a flag set between load and acceptance is never lost.
	assign ev_read_clear = rd_load && hit(avs_address, IDX_EVENT_STATUS);

	// Sticky flags, mask and the interrupt line.
	plg_event_flags u_events (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.event_i      (events),
		.read_clear_i (ev_read_clear),
		.mask_we_i    (wr_accept && hit(avs_address, IDX_EVENT_MASK)),
		.mask_data_i  (wr_mask[EVENT_W-1:0]),
		.status_o     (ev_status),
		.mask_o       (ev_mask),
		.irq_o        (irq_o)
	);

	// In enhanced mode the shared pin carries the clock unless disabled.
	assign force_ref = enhanced_mode_i & ~ref_clock_out_disable;

	// Status pin 0.
	plg_pin_drive #(.PIN(0)) u_pin0 (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.func_i       (pin0_function_choice),
		.clk_choice_i (pin0_clock_choice),
		.status_ind_i (status_ind_i[0]),
		.force_ref_i  (1'b0),
		.src_i        (src_i),
		.pin_o        (status_pin0_o)
	);

	// Status pin 1, shared with the reference clock output.
	plg_pin_drive #(.PIN(1)) u_pin1 (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.func_i       (pin1_function_choice),
		.clk_choice_i (pin1_clock_choice),
		.status_ind_i (status_ind_i[1]),
		.force_ref_i  (force_ref),
		.src_i        (src_i),
		.pin_o        (status_pin1_o)
	);

	// Status pin 2.
	plg_pin_drive #(.PIN(2)) u_pin2 (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.func_i       (pin2_function_choice),
		.clk_choice_i (3'h0),
		.status_ind_i (status_ind_i[2]),
		.force_ref_i  (1'b0),
		.src_i        (src_i),
		.pin_o        (status_pin2_o)
	);

	// Receive status pin meaning, only in RMII operation.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rmii_receive_pin_o <= 1'b0;
		end else if (rmii_mode_i) begin
			rmii_receive_pin_o <= rmii_receive_pin_meaning ? receive_valid_i : carrier_sense_dv_i;
		end else begin
			rmii_receive_pin_o <= carrier_sense_dv_i;
		end
	end

	// Termination control leaves the block through a flop.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mac_termination_o <= IMPEDANCE_RESET;
		end else begin
			mac_termination_o <= impedance;
		end
	end

endmodule // plg_pin_config
`default_nettype wire

// *** tb/plg_pin_config_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// Watches the bus handshake and the fixed pin paths of the configuration block.
module plg_pin_config_chk import plg_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	input  wire logic        rmii_mode_i,
	input  wire logic        carrier_sense_dv_i,
	input  wire logic [2:0]  status_ind_i,
	input  wire logic        status_pin0_o,
	input  wire logic        rmii_receive_pin_o,
	input  wire logic [1:0]  mac_termination_o
);
	// All checks share the block clock and its reset.
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A fresh request is answered after exactly one cycle of wait.
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one cycle");
	bus_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low longer than one cycle");
	bus_idle_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
		else $error("wait low without a request");
	// Pin 0 function code is fixed, so the pin always shows its status input.
	pin0_follow_a: assert property (status_pin0_o == $past(status_ind_i[0]))
		else $error("pin 0 does not follow its status");
	rmii_follow_a: assert property (!rmii_mode_i |=> rmii_receive_pin_o == $past(carrier_sense_dv_i))
		else $error("receive pin wrong outside RMII");
	// Termination only moves two cycles after a taken write.
	term_cause_a: assert property (!$stable(mac_termination_o) |-> $past(avs_write, 2))
		else $error("termination changed without a write");
	read_upper_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 12'h000
		|-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // plg_pin_config_chk

bind plg_pin_config plg_pin_config_chk i_chk (.clk_i, .rst_i, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .rmii_mode_i, .carrier_sense_dv_i, .status_ind_i, .status_pin0_o,
	.rmii_receive_pin_o, .mac_termination_o);
`default_nettype wire

// *** tb/plg_pin_config_test.sv ***
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench: reset values and register table rows first, then pin, mode and event cases.
module plg_pin_config_test import plg_pkg::*; ;
	typedef struct packed {
		logic [9:0]  idx;
		logic [15:0] w;
		logic [15:0] r;
	} plg_row_type;
	logic            clk_i = 1'b0, rst_i = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic [11:0]     avs_address = 12'h000;
	logic [31:0]     avs_writedata = 32'h0000_0000, avs_readdata;
	logic            avs_waitrequest, enh = 1'b0, rmii = 1'b0, hw_we = 1'b0, hw_d = 1'b0;
	logic            csdv = 1'b0, rxv = 1'b0, sq_we = 1'b0, p0, p1, p2, rpin, irq;
	logic [2:0]      ind = 3'h0;
	logic [3:0]      be = 4'h3;
	logic [1:0]      term;
	logic [15:0]     sq = 16'h0000, q;
	plg_sources_type src = 7'h00;
	plg_diag_type    diag = 3'h0;
	plg_diag_type    dv [2] = '{3'h5, 3'h6};
	logic [15:0]     dr [2] = '{16'h0020, 16'h0800};
	int              failures = 0, cmp_count = 0, cycles = 0;
	// Write value, expected readback; read-only bits must stay at reset.
	plg_row_type     rows [8] = '{'{IDX_IO_PIN, 16'hFFFF, 16'hFFC0}, '{IDX_PIN0, 16'hFFFF, 16'h0038},
		'{IDX_PIN1, 16'hFFFF, 16'h003F}, '{IDX_PIN2, 16'hFFFF, 16'h003F}, '{IDX_SIGNAL_QUAL, 16'hFFFF, 16'h0000},
		'{IDX_CABLE_DIAG, 16'hFFFF, 16'h0000}, '{10'h000, 16'hFFFF, 16'h0000}, '{IDX_EVENT_MASK, 16'hFFFF, 16'h0007}};

	plg_pin_config i_dut (.clk_i, .rst_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable(be), .avs_readdata, .avs_waitrequest, .enhanced_mode_i(enh),
		.rmii_meaning_strap_i(1'b1), .rmii_mode_i(rmii), .rmii_meaning_hw_we_i(hw_we), .rmii_meaning_hw_i(hw_d),
		.carrier_sense_dv_i(csdv), .receive_valid_i(rxv), .status_ind_i(ind), .src_i(src), .diag_i(diag),
		.signal_quality_we_i(sq_we), .signal_quality_i(sq), .status_pin0_o(p0), .status_pin1_o(p1),
		.status_pin2_o(p2), .rmii_receive_pin_o(rpin), .mac_termination_o(term), .irq_o(irq));

	// Clock at 200 MHz.
	initial forever #2.5 clk_i = ~clk_i;

	// Cuts a hang short.
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures = failures + 1;
			results();
		end
	end

	task automatic results();
		$display("Checks made %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask

	// One bus cycle: hold the request until wait is sampled low, then release.
	task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d);
		avs_address <= {idx, 2'h0};
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {16'h0000, d};
		@(posedge clk_i);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk_i);
		end
		q = avs_readdata[15:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rdchk(input string name, input logic [9:0] idx, input logic [15:0] e);
		bus(1'b0, idx, 16'h0000);
		chk(name, e, q);
	endtask

	// Expected pin level for a function code, from the current sources.
	function automatic logic exp_pin(input int pin, input logic [2:0] c);
		case (c)
			3'h0: return ind[pin];
			3'h1: return (pin == 1) ? src.pll_clock : 1'b0;
			3'h2: return src.wake_on_lan;
			3'h4: return src.interrupt_req;
			3'h7: return pin == 2;
			default: return (pin == 2) ? src.collision : (c == 3'h5) ? src.transmit_error :
				(c == 3'h6) ? src.ref_clock_25m : 1'b0;
		endcase
	endfunction

	task automatic reset_dut();
		rst_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	initial begin
		reset_dut();
		rdchk("io reset", IDX_IO_PIN, 16'h0100);
		rdchk("pin0 reset", IDX_PIN0, 16'h0008);
		rdchk("pin1 reset", IDX_PIN1, 16'h0008);
		rdchk("pin2 reset", IDX_PIN2, 16'h0008);
		rdchk("quality reset", IDX_SIGNAL_QUAL, 16'h0000);
		rdchk("diag reset", IDX_CABLE_DIAG, 16'h0000);
		rdchk("mask reset", IDX_EVENT_MASK, 16'h0000);
		foreach (rows[i]) begin
			bus(1'b1, rows[i].idx, rows[i].w);
			rdchk("row readback", rows[i].idx, rows[i].r);
		end
		chk("termination", 16'h0003, {14'h0000, term});
		// Every function code on pins 1 and 2, under two opposite source patterns.
		for (int p = 0; p < 2; p++) begin
			src <= p ? 7'h55 : 7'h2A;
			ind <= p ? 3'h2 : 3'h5;
			for (int pin = 1; pin < 3; pin++) begin
				for (int c = 0; c < 8; c++) begin
					bus(1'b1, (pin == 1) ? IDX_PIN1 : IDX_PIN2, {10'h000, CLK_PLL, c[2:0]});
					@(posedge clk_i);
					chk("pin function", {15'h0000, exp_pin(pin, c[2:0])}, {15'h0000, (pin == 1) ? p1 : p2});
				end
			end
		end
		src <= 7'h2A;
		bus(1'b1, IDX_PIN1, {10'h000, CLK_RECOVERED, FUNC_CLOCK});
		@(posedge clk_i);
		chk("recovered clock", 16'h0001, {15'h0000, p1});
		bus(1'b1, IDX_PIN1, {10'h000, 3'h2, FUNC_CLOCK});
		@(posedge clk_i);
		chk("reserved clock", 16'h0000, {15'h0000, p1});
		// Enhanced strap after a second reset: clock out until bit 6 frees the pin.
		ind <= 3'h0;
		enh <= 1'b1;
		// Wake source high and reference clock low, so the two pin 1 owners differ.
		src <= 7'h40;
		reset_dut();
		rdchk("pin1 enhanced", IDX_PIN1, 16'h000E);
		bus(1'b1, IDX_PIN1, 16'h000A);
		@(posedge clk_i);
		chk("clock out kept", 16'h0000, {15'h0000, p1});
		bus(1'b1, IDX_IO_PIN, 16'h0140);
		@(posedge clk_i);
		chk("general io", 16'h0001, {15'h0000, p1});
		// Receive pin meaning, by software and by hardware update.
		rmii <= 1'b1;
		rxv <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("rx valid", 16'h0001, {15'h0000, rpin});
		bus(1'b1, IDX_IO_PIN, 16'h0040);
		@(posedge clk_i);
		chk("carrier dv", 16'h0000, {15'h0000, rpin});
		hw_d <= 1'b1;
		hw_we <= 1'b1;
		@(posedge clk_i);
		hw_we <= 1'b0;
		rdchk("hw update", IDX_IO_PIN, 16'h0140);
		// Diagnosis results, then events raised masked, unmasked and cleared.
		foreach (dv[i]) begin
			diag <= dv[i];
			@(posedge clk_i);
			diag <= 3'h0;
			@(posedge clk_i);
			rdchk("diag result", IDX_CABLE_DIAG, dr[i]);
		end
		chk("irq masked", 16'h0000, {15'h0000, irq});
		bus(1'b1, IDX_EVENT_MASK, 16'h0001);
		@(posedge clk_i);
		chk("irq raised", 16'h0001, {15'h0000, irq});
		rdchk("event status", IDX_EVENT_STATUS, 16'h0007);
		@(posedge clk_i);
		chk("irq cleared", 16'h0000, {15'h0000, irq});
		rdchk("status cleared", IDX_EVENT_STATUS, 16'h0000);
		sq <= 16'hA5C3;
		sq_we <= 1'b1;
		@(posedge clk_i);
		sq_we <= 1'b0;
		rdchk("quality", IDX_SIGNAL_QUAL, 16'hA5C3);
		// Only the upper lane is enabled, so the low byte of pin 2 must keep its reset value.
		be <= 4'h2;
		bus(1'b1, IDX_PIN2, 16'h00FF);
		rdchk("lane one only", IDX_PIN2, 16'h0008);
		results();
	end
endmodule // plg_pin_config_test
`default_nettype wire
